// ### logic/smfd_defines.vh
// constants for the shift and move datapath slice
`ifndef SMFD_DEFINES_VH
`define SMFD_DEFINES_VH
// operation codes on op_sel
`define SMFD_OP_NONE 2'h0
`define SMFD_OP_SHL 2'h1
`define SMFD_OP_SHR 2'h2
`define SMFD_OP_MOV 2'h3
// destination bit values
`define SMFD_DEST_ACC 1'h0
`define SMFD_DEST_FILE 1'h1
// widths and reset values
`define SMFD_DATA_W 8
`define SMFD_ADDR_W 7
`define SMFD_ACC_RST 8'h00
`define SMFD_FLAG_RST 1'h0
`define SMFD_WE_RST 1'h0
`define SMFD_WADDR_RST 7'h00
`define SMFD_WDATA_RST 8'h00
// bit positions
`define SMFD_MSB 7
`define SMFD_LSB 0
`endif

// ### logic/smfd_alu.v
// combinational shift and move unit
`timescale 1ns/100ps
`default_nettype none
`include "smfd_defines.vh"
module smfd_alu (
    // operation
    input wire [1:0] op_sel,
    input wire [7:0] src,
    // results
    output reg [7:0] result,
    output reg carry_out,
    output reg carry_we,
    output wire zero_out
);
    always @* begin
        result = src;
        carry_out = 1'h0;
        carry_we = 1'h0;
        case (op_sel)
            `SMFD_OP_SHL: begin
                result = {src[6:0], 1'h0};
                carry_out = src[`SMFD_MSB];
                carry_we = 1'h1;
            end
            `SMFD_OP_SHR: begin
                result = {1'h0, src[7:1]};
                carry_out = src[`SMFD_LSB];
                carry_we = 1'h1;
            end
            `SMFD_OP_MOV: begin
                result = src;
            end
            default: begin
                result = src;
            end
        endcase
    end
    assign zero_out = (result == 8'h00);
endmodule // smfd_alu
`default_nettype wire

// ### logic/smfd_datapath.v
// shift and move file-register datapath slice

`timescale 1ns/100ps
`default_nettype none
`include "smfd_defines.vh"

module smfd_datapath #(
    parameter DATA_W = `SMFD_DATA_W
) (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // instruction
    input wire op_valid,
    input wire [1:0] op_sel,
    input wire dest_sel,
    input wire [6:0] file_addr,
    // file register read data
    input wire [7:0] file_rdata,
    // file register write back
    output reg file_we,
    output reg [6:0] file_waddr,
    output reg [7:0] file_wdata,
    // accumulator and status
    output reg [7:0] acc,
    output reg carry_flag,
    output reg zero_flag
);

    // ****************************************
    // local constants
    // ****************************************
    // the alu is fixed at eight bits, so DATA_W must stay at its default
    localparam ADDR_W = `SMFD_ADDR_W;

    // ****************************************
    // decode helpers
    // ****************************************
    // idle code or low valid must leave every register alone except file_we, which drops to 0
    function op_taken;
        input valid;
        input [1:0] op;
        begin
            op_taken = valid && (op != `SMFD_OP_NONE);
        end
    endfunction

    // both write-back targets share one decode so they can never both fire
    function dest_matches;
        input valid;
        input [1:0] op;
        input dest;
        input want;
        begin
            dest_matches = op_taken(valid, op) && (dest == want);
        end
    endfunction

    // ****************************************
    // execution unit
    // ****************************************
    wire [DATA_W-1:0] result;
    wire carry_out;
    wire carry_we;
    wire zero_out;

    smfd_alu u_alu (
        .op_sel(op_sel),
        .src(file_rdata),
        .result(result),
        .carry_out(carry_out),
        .carry_we(carry_we),
        .zero_out(zero_out)
    );

    // ****************************************
    // load enables
    // ****************************************
    wire active;
    wire load_file;
    wire load_acc;
    wire load_carry;

    assign active = op_taken(op_valid, op_sel);
    assign load_file = dest_matches(op_valid, op_sel, dest_sel, `SMFD_DEST_FILE);
    assign load_acc = dest_matches(op_valid, op_sel, dest_sel, `SMFD_DEST_ACC);
    // move leaves the carry as it was
    assign load_carry = active && carry_we;

    // ****************************************
    // next state
    // ****************************************
    reg next_file_we;
    reg [ADDR_W-1:0] next_file_waddr;
    reg [DATA_W-1:0] next_file_wdata;
    reg next_carry;
    reg next_zero;
    wire [DATA_W-1:0] next_acc;

    // write data follows every taken op; only file_we says it lands
    always @* begin
        next_file_we = load_file;
        next_file_waddr = file_waddr;
        next_file_wdata = file_wdata;
        if (active) begin
            next_file_waddr = file_addr;
            next_file_wdata = result;
        end
    end

    // ****************************************
    // flag updates
    // ****************************************
    always @* begin
        next_carry = carry_flag;
        if (load_carry) begin
            next_carry = carry_out;
        end
    end

    // every taken op, move included, refreshes the zero flag
    always @* begin
        next_zero = zero_flag;
        if (active) begin
            next_zero = zero_out;
        end
    end

    // ****************************************
    // accumulator slices
    // ****************************************
    // one identical slice per bit, selected by the destination decode
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < DATA_W; bit_idx = bit_idx + 1) begin : g_acc_bit
            assign next_acc[bit_idx] = load_acc ? result[bit_idx] : acc[bit_idx];
        end
    endgenerate

    // ****************************************
    // write strobe
    // ****************************************
    // one-cycle pulse; no forwarding, so the store must not read it back early
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_we <= `SMFD_WE_RST;
        end else begin
            file_we <= next_file_we;
        end
    end

    // ****************************************
    // write address
    // ****************************************
    // holds until the next taken op
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_waddr <= `SMFD_WADDR_RST;
        end else begin
            file_waddr <= next_file_waddr;
        end
    end

    // ****************************************
    // write data
    // ****************************************
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_wdata <= `SMFD_WDATA_RST;
        end else begin
            file_wdata <= next_file_wdata;
        end
    end

    // ****************************************
    // accumulator
    // ****************************************
    // loaded only when the destination bit picks it
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc <= `SMFD_ACC_RST;
        end else begin
            acc <= next_acc;
        end
    end

    // ****************************************
    // carry flag
    // ****************************************
    // only shifts reach here, see load_carry
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            carry_flag <= `SMFD_FLAG_RST;
        end else begin
            carry_flag <= next_carry;
        end
    end

    // ****************************************
    // zero flag
    // ****************************************
    // reads clear after reset until the first taken op
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_flag <= `SMFD_FLAG_RST;
        end else begin
            zero_flag <= next_zero;
        end
    end

endmodule // smfd_datapath
`default_nettype wire

// ### tb/smfd_assertions.sv
// checker for the shift and move datapath
`timescale 1ns/100ps
`default_nettype none
module smfd_assertions (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // instruction
    input wire op_valid,
    input wire [1:0] op_sel,
    input wire dest_sel,
    input wire [6:0] file_addr,
    input wire [7:0] file_rdata,
    // results
    input wire file_we,
    input wire [6:0] file_waddr,
    input wire [7:0] file_wdata,
    input wire [7:0] acc,
    input wire carry_flag,
    input wire zero_flag
);
    wire tk = op_valid && op_sel != 2'h0;
    wire l = tk && op_sel == 2'h1;
    wire r = tk && op_sel == 2'h2;
    wire m = tk && op_sel == 2'h3;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    shl_carry_a: assert property (l |=> carry_flag == $past(file_rdata[7]))
        else $error("bad left carry");
    shl_data_a: assert property (l && !dest_sel |=> acc == $past(file_rdata) << 1)
        else $error("bad left shift");
    shr_data_a: assert property (r && dest_sel |=>
        file_wdata == $past(file_rdata) >> 1) else $error("bad right shift");
    shr_carry_a: assert property (r |=> carry_flag == $past(file_rdata[0]))
        else $error("bad right carry");
    mov_carry_a: assert property (m |=> $stable(carry_flag))
        else $error("move touched carry");
    mov_file_a: assert property (m && dest_sel |=>
        file_we && file_wdata == $past(file_rdata)) else $error("bad move");
    zero_flag_a: assert property (tk |=>
        zero_flag == (($past(dest_sel) ? file_wdata : acc) == 8'h00)) else $error("bad zero");
    file_dest_a: assert property (tk && dest_sel |=>
        file_we && file_waddr == $past(file_addr) && $stable(acc)) else $error("bad write");
    idle_hold_a: assert property (!tk |=>
        !file_we && $stable(acc) && $stable(carry_flag) && $stable(zero_flag))
        else $error("idle op changed state");
    mov_zero_a: assert property (m |=> zero_flag == ($past(file_rdata) == 8'h00))
        else $error("bad move zero");
endmodule // smfd_assertions
bind smfd_datapath smfd_assertions u_chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .op_valid(op_valid),
    .op_sel(op_sel),
    .dest_sel(dest_sel),
    .file_addr(file_addr),
    .file_rdata(file_rdata),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .acc(acc),
    .carry_flag(carry_flag),
    .zero_flag(zero_flag)
);
`default_nettype wire

// ### tb/tb_top.sv
// testbench for the shift and move datapath
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    reg core_clk = 1'h0, sys_rst = 1'h1, op_valid = 1'h0, dest_sel = 1'h0, ec = 1'h0;
    reg ez = 1'h0;
    reg [1:0] op_sel = 2'h0;
    reg [6:0] file_addr = 7'h00;
    reg [7:0] file_rdata = 8'h00, ea = 8'h00;
    integer n_fail = 0, samples_checked = 0;
    wire file_we, carry_flag, zero_flag;
    wire [6:0] file_waddr;
    wire [7:0] file_wdata, acc;
    smfd_datapath DUT (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .op_valid(op_valid),
        .op_sel(op_sel),
        .dest_sel(dest_sel),
        .file_addr(file_addr),
        .file_rdata(file_rdata),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .acc(acc),
        .carry_flag(carry_flag),
        .zero_flag(zero_flag)
    );
    always #25 core_clk = ~core_clk;
    task chk(input [15:0] seen, input [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run(input [1:0] s, input d, input [6:0] a, input [7:0] v);
        reg [7:0] r;
        r = s == 2'h1 ? v << 1 : s == 2'h2 ? v >> 1 : v;
        @(posedge core_clk);
        op_valid <= 1'h1;
        op_sel <= s;
        dest_sel <= d;
        file_addr <= a;
        file_rdata <= v;
        @(posedge core_clk);
        op_valid <= 1'h0;
        #1;
        if (s && !d) ea = r;
        if (s == 2'h1) ec = v[7];
        if (s == 2'h2) ec = v[0];
        if (s) ez = (r == 8'h00);
        chk({carry_flag, acc}, {ec, ea});
        chk(zero_flag, ez);
        chk(file_we, s && d);
        if (s && d) chk({file_waddr, file_wdata}, {a, r});
    endtask
    task t_shift;
        run(2'h1, 1'h0, 7'h05, 8'h41);
        run(2'h1, 1'h1, 7'h7F, 8'h80);
        run(2'h2, 1'h0, 7'h00, 8'h81);
        run(2'h2, 1'h1, 7'h33, 8'h01);
        $display("shift test done");
    endtask
    task t_move;
        run(2'h3, 1'h1, 7'h2A, 8'h00);
        run(2'h3, 1'h0, 7'h01, 8'hA5);
        run(2'h0, 1'h1, 7'h11, 8'hFF);
        $display("move test done");
    endtask
    task t_idle;
        @(posedge core_clk);
        op_valid <= 1'h0;
        op_sel <= 2'h1;
        dest_sel <= 1'h1;
        file_rdata <= 8'h00;
        @(posedge core_clk);
        #1;
        chk({file_we, carry_flag, acc}, {1'h0, ec, ea});
        chk(zero_flag, ez);
        $display("idle test done");
    endtask
    task t_reset;
        run(2'h2, 1'h0, 7'h10, 8'hFF);
        @(posedge core_clk);
        sys_rst <= 1'h1;
        #1;
        chk({file_we, file_waddr, file_wdata}, 16'h0000);
        chk({carry_flag, zero_flag, acc}, 16'h0000);
        ea = 8'h00;
        ec = 1'h0;
        ez = 1'h0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        run(2'h1, 1'h1, 7'h44, 8'hC0);
        $display("reset test done");
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'h0;
        t_shift;
        t_move;
        t_idle;
        t_reset;
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
